// ### verilog/adcc_top.sv
// Converter control and status registers with a classic Wishbone slave.
//
// Overview of operation
// - Start bit pulsed high then low begins a conversion on the falling step.
// - Start bit held high keeps converter in reset and busy at one.
// - Read-only busy flag is one while converting, zero when complete.
// - Three pin bits make port pins zero to two analog inputs when set.
// - All pin bits clear puts the converter into power-down.
// - Power-off bit in clock register, one powers down, resets to zero.
// - Divider field: 000 /2, 001 /8, 010 /32, 100 /1, 101 /4, 110 /16.
// - Channel field routes input zero, one or two to the converter.
// - Converter powered only when some pin bit set and power-off clear.
// - End of conversion clears busy and raises the request flag.
// - Halt does not change converter power state.
`timescale 1ns/1ps
module adcc_top (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic WB_ERR_O,
  input wire logic HALT_REQ,
  output logic [2:0] ANALOG_PIN_ENABLE,
  output logic [1:0] CHANNEL_SELECT,
  output logic [2:0] CONVERTER_CLOCK_DIVIDER,
  output logic CONVERTER_POWERED,
  output logic CONVERTER_RESET,
  output logic CONVERTER_TICK,
  output logic CONVERSION_DONE_IRQ,
  output logic TEST_MODE
);
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  // Held means the start bit is up and the converter sits in reset.
  typedef enum logic [1:0] {
    seq_idle,
    seq_held,
    seq_run
  } adcc_seq_e;

  adcc_pkg::adcc_ctrl_s ctrl_q;
  adcc_pkg::adcc_clk_s clk_q;
  adcc_seq_e seq_q;
  adcc_seq_e seq_d;
  logic busy;
  logic last_tick;
  logic [4:0] ticks_q;
  logic ack_q;
  logic err_q;
  logic [31:0] rdata_q;
  logic done_q;
  logic tick;

  // Unimplemented bits are never stored, so they read back as zero.
  function automatic logic [7:0] ctrl_image(input adcc_pkg::adcc_ctrl_s c, input logic b);
    ctrl_image = {c.start, b, 1'b0, c.pins, c.chan};
  endfunction

  function automatic logic [7:0] clk_image(input adcc_pkg::adcc_clk_s c);
    clk_image = {c.test, c.power_off, 3'h0, c.div};
  endfunction

  wire req = WB_CYC_I && WB_STB_I && !ack_q && !err_q;
  wire hit_ctrl = WB_ADR_I == adcc_pkg::CTRL_ADDR;
  wire hit_clk = WB_ADR_I == adcc_pkg::CLKPWR_ADDR;
  wire mapped = hit_ctrl || hit_clk;
  // A write lands at the edge where the master sees ack, while it still holds
  // the request, so state never changes before the answer is given.
  wire commit = WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0] && ack_q;
  wire wr_ctrl = commit && hit_ctrl;
  wire wr_clk = commit && hit_clk;
  wire powered = (ctrl_q.pins != adcc_pkg::PIN_NONE) && !clk_q.power_off;
  wire run = powered && busy && !ctrl_q.start;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Bit 5 of control and bits 5..3 of clock register are not stored.
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ctrl_q <= '0;
    end else if (wr_ctrl) begin
      ctrl_q.start <= WB_DAT_I[adcc_pkg::START_BIT];
      ctrl_q.pins <= WB_DAT_I[adcc_pkg::PIN_LSB +: 3];
      ctrl_q.chan <= WB_DAT_I[adcc_pkg::CHAN_LSB +: 2];
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      clk_q <= '{test: 1'b1, power_off: 1'b0, div: adcc_pkg::DIV2};
    end else if (wr_clk) begin
      clk_q.test <= WB_DAT_I[adcc_pkg::TEST_BIT];
      clk_q.power_off <= WB_DAT_I[adcc_pkg::PWROFF_BIT];
      clk_q.div <= WB_DAT_I[adcc_pkg::DIV_LSB +: 3];
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  // The analog core is outside; a conversion is modelled as a fixed count of
  // converter clock ticks so busy has a defined length. A powered-down
  // converter never ticks, so busy then stays high until power returns.
  assign busy = seq_q != seq_idle;
  assign last_tick = tick && (ticks_q == 5'(adcc_pkg::CONV_TICKS - 5'h01));

  always_comb begin
    seq_d = seq_q;
    case (seq_q)
      seq_idle: begin
        if (ctrl_q.start) begin
          seq_d = seq_held;
        end
      end
      seq_held: begin
        if (!ctrl_q.start) begin
          seq_d = seq_run;
        end
      end
      seq_run: begin
        if (ctrl_q.start) begin
          seq_d = seq_held;
        end else if (last_tick) begin
          seq_d = seq_idle;
        end
      end
      default: begin
        seq_d = seq_idle;
      end
    endcase
  end

  // Busy reads one from reset, as a conversion that waits for power.
  always_ff @(posedge MCLK) begin
    if (RST) begin
      seq_q <= seq_run;
    end else begin
      seq_q <= seq_d;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST || ctrl_q.start || last_tick) begin
      ticks_q <= '0;
    end else if (tick) begin
      ticks_q <= ticks_q + 5'h01;
    end
  end

  // Done is a flop so that it rises together with busy reading zero.
  always_ff @(posedge MCLK) begin
    if (RST) begin
      done_q <= 1'b0;
    end else begin
      done_q <= busy && (seq_d == seq_idle);
    end
  end

  adcc_clkdiv u_div (
    .clk(MCLK),
    .rst(RST),
    .run(run),
    .div(clk_q.div),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Wishbone slave: one wait state, error on unmapped address
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && mapped;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      err_q <= 1'b0;
    end else begin
      err_q <= req && !mapped;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      rdata_q <= '0;
    end else if (req && hit_ctrl) begin
      rdata_q <= {24'h0, ctrl_image(ctrl_q, busy)};
    end else if (req && hit_clk) begin
      rdata_q <= {24'h0, clk_image(clk_q)};
    end else begin
      rdata_q <= '0;
    end
  end

  // HALT_REQ is deliberately unused: halt leaves power as it was.
  wire halt_unused = HALT_REQ;

  assign WB_ACK_O = ack_q;
  assign WB_ERR_O = err_q;
  assign WB_DAT_O = rdata_q;
  assign ANALOG_PIN_ENABLE = ctrl_q.pins;
  assign CHANNEL_SELECT = ctrl_q.chan;
  assign CONVERTER_CLOCK_DIVIDER = clk_q.div;
  assign CONVERTER_POWERED = powered;
  assign CONVERTER_RESET = ctrl_q.start;
  assign CONVERTER_TICK = tick;
  assign CONVERSION_DONE_IRQ = done_q;
  assign TEST_MODE = clk_q.test;
endmodule

// ### verilog/adcc_pkg.sv
// Package with register map, field positions and encodings of the converter control block.
package adcc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] CLKPWR_ADDR = 8'h04;
  localparam logic [7:0] CTRL_RESET = 8'h40;
  localparam logic [7:0] CLKPWR_RESET = 8'h80;
  localparam int START_BIT = 7;
  localparam int BUSY_BIT = 6;
  localparam int PIN_LSB = 2;
  localparam int TEST_BIT = 7;
  localparam int PWROFF_BIT = 6;
  localparam logic [2:0] PIN_NONE = 3'h0;
  localparam int CHAN_LSB = 0;
  localparam int DIV_LSB = 0;
  // ----------------------------------------------------------------
  // Clock divider codes and conversion length
  // ----------------------------------------------------------------
  localparam logic [2:0] DIV2 = 3'h0;
  localparam logic [2:0] DIV8 = 3'h1;
  localparam logic [2:0] DIV32 = 3'h2;
  localparam logic [2:0] DIV1 = 3'h4;
  localparam logic [2:0] DIV4 = 3'h5;
  localparam logic [2:0] DIV16 = 3'h6;
  localparam logic [2:0] DIV_UNDEF_LO = 3'h3;
  localparam logic [2:0] DIV_UNDEF_HI = 3'h7;
  localparam logic [4:0] LAST_DIV1 = 5'h00;
  localparam logic [4:0] LAST_DIV2 = 5'h01;
  localparam logic [4:0] LAST_DIV4 = 5'h03;
  localparam logic [4:0] LAST_DIV8 = 5'h07;
  localparam logic [4:0] LAST_DIV16 = 5'h0f;
  localparam logic [4:0] LAST_DIV32 = 5'h1f;
  localparam logic [4:0] CONV_TICKS = 5'h10;
  localparam logic [1:0] CH_RESERVED = 2'h3;

  typedef struct packed {
    logic start;
    logic [2:0] pins;
    logic [1:0] chan;
  } adcc_ctrl_s;

  typedef struct packed {
    logic test;
    logic power_off;
    logic [2:0] div;
  } adcc_clk_s;
endpackage

// ### verilog/adcc_clkdiv.sv
// Converter clock tick generator selected by the divider field.
`timescale 1ns/1ps
module adcc_clkdiv (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [2:0] div,
  output logic tick
);
  logic [4:0] cnt_q;

  // Undefined codes give no tick, so a conversion simply stalls.
  function automatic logic [4:0] last_count(input logic [2:0] d);
    case (d)
      adcc_pkg::DIV1: last_count = adcc_pkg::LAST_DIV1;
      adcc_pkg::DIV2: last_count = adcc_pkg::LAST_DIV2;
      adcc_pkg::DIV4: last_count = adcc_pkg::LAST_DIV4;
      adcc_pkg::DIV8: last_count = adcc_pkg::LAST_DIV8;
      adcc_pkg::DIV16: last_count = adcc_pkg::LAST_DIV16;
      adcc_pkg::DIV32: last_count = adcc_pkg::LAST_DIV32;
      default: last_count = adcc_pkg::LAST_DIV32;
    endcase
  endfunction

  wire valid_div = (div != adcc_pkg::DIV_UNDEF_LO) && (div != adcc_pkg::DIV_UNDEF_HI);

  always_ff @(posedge clk) begin
    if (rst || !run || cnt_q >= last_count(div)) begin
      cnt_q <= 5'h00;
    end else begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  assign tick = run && valid_div && (cnt_q >= last_count(div));
endmodule

// ### sim/adcc_chk_sva.sv
// Port assertions for the converter control block.
`timescale 1ns/1ps
module adcc_chk (
  input logic MCLK,
  input logic RST,
  input logic WB_CYC_I,
  input logic WB_STB_I,
  input logic WB_ACK_O,
  input logic WB_ERR_O,
  input logic [2:0] ANALOG_PIN_ENABLE,
  input logic CONVERTER_POWERED,
  input logic CONVERTER_RESET,
  input logic CONVERTER_TICK,
  input logic CONVERSION_DONE_IRQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  endsequence
  sequence s_held;
    CONVERTER_RESET ##1 CONVERTER_RESET;
  endsequence
  a_bus_answer: assert property (s_req |=> WB_ACK_O || WB_ERR_O) else $error("no answer");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  a_err_pulse: assert property (WB_ERR_O |=> !WB_ERR_O) else $error("err too long");
  a_ack_err: assert property (!(WB_ACK_O && WB_ERR_O)) else $error("ack with err");
  a_pins_off: assert property (ANALOG_PIN_ENABLE == 3'h0 |-> !CONVERTER_POWERED)
    else $error("powered without pins");
  a_tick_power: assert property (CONVERTER_TICK |-> CONVERTER_POWERED)
    else $error("tick while off");
  a_reset_done: assert property (s_held |-> !CONVERSION_DONE_IRQ)
    else $error("done during reset");
  a_done_pulse: assert property (CONVERSION_DONE_IRQ |=> !CONVERSION_DONE_IRQ)
    else $error("done too long");
endmodule
bind adcc_top adcc_chk chk (.MCLK(MCLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O), .ANALOG_PIN_ENABLE(ANALOG_PIN_ENABLE),
  .CONVERTER_POWERED(CONVERTER_POWERED), .CONVERTER_RESET(CONVERTER_RESET),
  .CONVERTER_TICK(CONVERTER_TICK), .CONVERSION_DONE_IRQ(CONVERSION_DONE_IRQ));

// ### sim/adcc_core_model.sv
// Behavioural model of the conversion core that measures converter tick spacing.
`timescale 1ns/1ps
module adcc_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic conv_rst,
  input wire logic tick,
  output int gap
);
  int cnt_q;
  // Only the last spacing is kept, so the odd first tick after a start is forgotten.
  always_ff @(posedge clk) begin
    if (rst || conv_rst) begin
      cnt_q <= 0;
    end else if (tick) begin
      gap <= cnt_q + 1;
      cnt_q <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule

// ### sim/test_adc_control_registers.sv
// Self-checking testbench for the converter control registers.
`timescale 1ns/1ps
module test_adc_control_registers;
  logic clk = 0, rst = 1, req = 0, we = 0, halt = 0, e, ack, err, rs, dn, pw, tk, tm;
  logic [7:0] adr = 8'h0, r;
  logic [31:0] dat = 32'h0, dato;
  logic [2:0] pins, dv3;
  logic [1:0] ch;
  logic [2:0] cd[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  int dv[6] = '{2, 8, 32, 1, 4, 16};
  int bad_count = 0, checks_done = 0, gap, n;
  always #2 clk = ~clk;
  adcc_top uut (.MCLK(clk), .RST(rst), .WB_CYC_I(req), .WB_STB_I(req), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_SEL_I(4'h1), .WB_DAT_O(dato), .WB_ACK_O(ack),
    .WB_ERR_O(err), .HALT_REQ(halt), .ANALOG_PIN_ENABLE(pins), .CHANNEL_SELECT(ch),
    .CONVERTER_CLOCK_DIVIDER(dv3), .CONVERTER_POWERED(pw), .CONVERTER_RESET(rs),
    .CONVERTER_TICK(tk), .CONVERSION_DONE_IRQ(dn), .TEST_MODE(tm));
  adcc_core_model core (.clk(clk), .rst(rst), .conv_rst(rs), .tick(tk), .gap(gap));
  // ----------------------------------------------------------------
  // Bus and checking tasks
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic ck(input logic [7:0] g, input logic [7:0] x);
    checks_done++;
    if (g !== x) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    req <= 1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && err !== 1'b1 && k < 50);
    r = dato[7:0];
    e = err;
    req <= 0;
    if (k == 50) begin
      bad_count++;
      wrap_up();
    end
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    wb(0, a, 8'h0);
    ck(r, x);
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    rd(8'h00, 8'h40);
    rd(8'h04, 8'h80);
    ck({7'h0, tm}, 8'h1);
    ck({7'h0, pw}, 8'h0);
    wb(1, 8'h00, 8'ha5);
    rd(8'h00, 8'hc5);
    ck({7'h0, rs}, 8'h1);
    ck({3'h0, pins, ch}, 8'h05);
    wb(1, 8'h04, 8'hbc);
    rd(8'h04, 8'h84);
    ck({7'h0, pw}, 8'h1);
    wb(1, 8'h04, 8'hc4);
    ck({7'h0, pw}, 8'h0);
    halt <= 1;
    repeat (2) @(posedge clk);
    ck({7'h0, pw}, 8'h0);
    wb(1, 8'h04, 8'h84);
    ck({7'h0, pw}, 8'h1);
    wb(0, 8'h08, 8'h0);
    ck({7'h0, e}, 8'h1);
    $display("registers done");
    for (int i = 0; i < 6; i++) begin
      wb(1, 8'h04, {5'h10, cd[i]});
      ck({5'h0, dv3}, {5'h0, cd[i]});
      wb(1, 8'h00, 8'h84);
      wb(1, 8'h00, 8'h04);
      rd(8'h00, 8'h44);
      n = 3;
      do begin
        @(posedge clk);
        n++;
      end while (dn !== 1'b1 && n < 700);
      if (n >= 700) begin
        bad_count++;
        wrap_up();
      end
      ck({7'h0, 1'(n >= 15 * dv[i] && n <= 17 * dv[i] + 8)}, 8'h1);
      ck(gap[7:0], dv[i][7:0]);
      rd(8'h00, 8'h04);
      $display("divider %0d done", dv[i]);
    end
    wrap_up();
  end
endmodule
